// ### logic/vpi_regs.vh
`ifndef VPI_REGS_VH
`define VPI_REGS_VH
`define VPI_ADDR_A        8'hDA
`define VPI_ADDR_B        8'hDB
`define VPI_ADDR_SRC      8'hD0
`define VPI_ADDR_SRCMAP   8'hD1
`define VPI_SEL_BIT       3
`define VPI_CMD_EOI_BIT   5
`define VPI_CMD_SPEC_BIT  6
`define VPI_CMD_MODE_BIT  7
`define VPI_CFG_SPACE_BIT 2
`define VPI_MODE_NESTED   2'h0
`define VPI_MODE_ROTATE   2'h1
`define VPI_MODE_SPECIFIC 2'h2
`define VPI_MODE_POLLED   2'h3
`define VPI_MASK_RESET    8'hFF
`define VPI_SRC_COUNT     26
`endif

// ### logic/vpi_route.v
`timescale 1ns/1ps
`default_nettype none
module vpi_route #(
    parameter N_SRC = 26
) (
    input  wire             i_clock,
    input  wire             i_rst,
    input  wire             i_wr,
    input  wire [4:0]       i_sel,
    input  wire [2:0]       i_level,
    input  wire             i_en,
    input  wire [N_SRC-1:0] i_src,
    output reg  [7:0]       o_req
);
    // per-source jumper table: enable bit plus target level
    wire [4*N_SRC-1:0] jumper;
    reg  [7:0]         next_req;
    integer            k;
    genvar             g;
    generate
        for (g = 0; g < N_SRC; g = g + 1) begin : g_jmp
            reg [3:0] entry;
            always @(posedge i_clock) begin
                if (i_rst)
                    entry <= 4'h0;
                else if (i_wr && {27'h0, i_sel} == g)
                    entry <= {i_en, i_level};
            end
            assign jumper[4*g +: 4] = entry;
        end
    endgenerate
    always @* begin
        next_req = 8'h00;
        for (k = 0; k < N_SRC; k = k + 1)
            if (jumper[4*k+3] && i_src[k])
                next_req[jumper[4*k +: 3]] = 1'b1;
    end
    always @(posedge i_clock) begin
        if (i_rst)
            o_req <= 8'h00;
        else
            o_req <= next_req;
    end
endmodule
`default_nettype wire

// ### logic/vpi_unit.v
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "vpi_regs.vh"
// register map, all bytes:
//   A write, bit5 set     : end of service for the top in-service level
//   A write, bit7 set     : mode word; [1:0] scheme, bit2 selects 8-byte
//                           entries, and the next B write loads the base
//   A write, bits 7,5 low : bit3 picks the A read source, bit6 loads
//                           the lowest-ranked level from [2:0]
//   A read                : polled status, else in-service or requests
//   B write / read        : mask, or base high byte right after a mode word
//   SRC write / read      : staging word {enable, level} for routing
//   SRCMAP write          : [4:0] names the source that takes the staging
// timing: a pin change reaches o_int about five clocks later (three
// synchroniser stages, the agreement register and the routing register);
// software must allow for that before it expects a level to show up or
// to drop after an end-of-service.
// limitation: requests are levels, not latched edges; a source that
// drops before it is acknowledged is simply forgotten.
module vpi_unit #(
    parameter N_SRC = `VPI_SRC_COUNT
) (
    input  wire        i_clock,
    input  wire        i_rst,
    input  wire [7:0]  i_addr,
    input  wire [7:0]  i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [7:0]  o_rdata,
    input  wire [3:0]  i_ppi_in_full,
    input  wire [3:0]  i_ppi_out_empty,
    input  wire        i_ser_rx_ready,
    input  wire        i_ser_tx_empty,
    input  wire [1:0]  i_timer_out,
    input  wire [8:0]  i_bus_int,
    input  wire [7:0]  i_ext_int,
    input  wire        i_mains_low_warning,
    output wire        o_int,
    input  wire        i_inta,
    output reg  [15:0] o_vector,
    output reg         o_vector_valid
);
    wire [N_SRC-1:0] pins;
    wire [N_SRC-1:0] src;
    // the parallel port asserts when its input is full or output empty
    assign pins = {i_mains_low_warning,
                   i_ext_int,
                   i_bus_int,
                   i_timer_out,
                   i_ser_tx_empty, i_ser_rx_ready,
                   i_ppi_in_full | i_ppi_out_empty};

    // every pin runs through three flops and a level only counts once
    // stages two and three agree, so a one-cycle glitch never routes
    genvar s;
    generate
        for (s = 0; s < N_SRC; s = s + 1) begin : g_sync
            reg [2:0] stage;
            reg       level;
            always @(posedge i_clock) begin
                if (i_rst) begin
                    stage <= 3'h0;
                    level <= 1'b0;
                end else begin
                    stage <= {stage[1:0], pins[s]};
                    if (stage[1] == stage[2])
                        level <= stage[1];
                end
            end
            assign src[s] = level;
        end
    endgenerate

    wire [7:0] irr;
    reg  [2:0] map_level;
    reg        map_en;
    // source jumper table, written at its own address
    vpi_route #(.N_SRC(N_SRC)) u_route (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_wr    (i_wr && i_addr == `VPI_ADDR_SRCMAP),
        .i_sel   (i_wdata[4:0]),
        .i_level (map_level),
        .i_en    (map_en),
        .i_src   (src),
        .o_req   (irr)
    );

    reg  [7:0]  mask;
    wire [7:0]  isr;
    reg  [7:0]  next_rdata;
    reg  [1:0]  mode;
    reg  [2:0]  lowest;
    reg         spacing8;
    reg  [15:0] base;
    reg         rd_isr;
    reg         ini_pend;

    wire wr_a = i_wr && i_addr == `VPI_ADDR_A;
    wire wr_b = i_wr && i_addr == `VPI_ADDR_B;
    wire cmd_eoi  = wr_a && i_wdata[`VPI_CMD_EOI_BIT];
    wire cmd_mode = wr_a && !i_wdata[`VPI_CMD_EOI_BIT]
                    && i_wdata[`VPI_CMD_MODE_BIT];
    wire cmd_sel  = wr_a && !i_wdata[`VPI_CMD_EOI_BIT]
                    && !i_wdata[`VPI_CMD_MODE_BIT];

    // rotate so that the level after "lowest" sits at rank zero; the
    // nested scheme skips the rotation, so line 0 always ranks first
    wire [7:0] pend = irr & ~mask;
    wire [2:0] first_lvl = lowest + 3'h1;
    wire [7:0] rot_pend;
    wire [7:0] rot_isr;
    genvar r;
    generate
        for (r = 0; r < 8; r = r + 1) begin : g_rank
            assign rot_pend[r] = pend[(r + first_lvl) % 8];
            assign rot_isr[r]  = isr[(r + first_lvl) % 8];
        end
    endgenerate
    wire [2:0] eff_low = (mode == `VPI_MODE_NESTED) ? 3'h7 : lowest;

    function [3:0] first_set;
        input [7:0] v;
        integer j;
        begin
            first_set = 4'h8;
            for (j = 7; j >= 0; j = j - 1)
                if (v[j])
                    first_set = j[3:0];
        end
    endfunction

    wire [3:0] win_rank = first_set(mode == `VPI_MODE_NESTED ? pend
                                                             : rot_pend);
    wire [3:0] isr_rank = first_set(mode == `VPI_MODE_NESTED ? isr
                                                             : rot_isr);
    wire [2:0] win_lvl  = (mode == `VPI_MODE_NESTED) ? win_rank[2:0]
                        : win_rank[2:0] + eff_low + 3'h1;
    wire       has_win  = !win_rank[3];
    // rank comparison: smaller rank is higher priority
    wire       outranks = has_win && (win_rank < isr_rank);
    assign o_int = outranks && mode != `VPI_MODE_POLLED;

    wire [2:0] eoi_lvl = (mode == `VPI_MODE_NESTED) ? isr_rank[2:0]
                       : isr_rank[2:0] + lowest + 3'h1;
    wire       take = i_inta && o_int;
    wire       eoi_ok = cmd_eoi && isr != 8'h00;

    // one in-service flag per level; a grant and an end-of-service aimed
    // at the same level in one cycle leave the flag set
    genvar v;
    generate
        for (v = 0; v < 8; v = v + 1) begin : g_lvl
            reg  in_svc;
            wire grant  = take && {29'h0, win_lvl} == v;
            wire retire = eoi_ok && {29'h0, eoi_lvl} == v;
            always @(posedge i_clock) begin
                if (i_rst)
                    in_svc <= 1'b0;
                else if (grant)
                    in_svc <= 1'b1;
                else if (retire)
                    in_svc <= 1'b0;
            end
            assign isr[v] = in_svc;
        end
    endgenerate

    // vector register: loaded on every accepted acknowledge, held otherwise
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_vector       <= 16'h0000;
            o_vector_valid <= 1'b0;
        end else begin
            o_vector_valid <= take;
            if (take) begin
                // table base plus level times the spacing
                o_vector <= spacing8
                    ? {base[15:6], win_lvl, 3'h0}
                    : {base[15:5], win_lvl, 2'h0};
            end
        end
    end

    // operating scheme and entry spacing, rewritable at any time
    always @(posedge i_clock) begin
        if (i_rst) begin
            mode     <= `VPI_MODE_NESTED;
            spacing8 <= 1'b0;
        end else if (cmd_mode) begin
            mode     <= i_wdata[1:0];
            spacing8 <= i_wdata[`VPI_CFG_SPACE_BIT];
        end
    end

    // lowest-ranked level; the three commands never meet in one cycle
    always @(posedge i_clock) begin
        if (i_rst) begin
            lowest <= 3'h7;
        end else if (cmd_sel && i_wdata[`VPI_CMD_SPEC_BIT]) begin
            lowest <= i_wdata[2:0];
        end else if (cmd_mode && i_wdata[1:0] == `VPI_MODE_NESTED) begin
            lowest <= 3'h7;
        end else if (eoi_ok && mode == `VPI_MODE_ROTATE) begin
            lowest <= eoi_lvl;
        end
    end

    // read selector and base-load sequencing on the two shared addresses
    always @(posedge i_clock) begin
        if (i_rst) begin
            rd_isr   <= 1'b0;
            ini_pend <= 1'b0;
        end else begin
            if (cmd_sel)
                rd_isr <= i_wdata[`VPI_SEL_BIT];
            // after a mode word the next write to B is the base, not the mask
            if (cmd_mode)
                ini_pend <= 1'b1;
            else if (wr_b)
                ini_pend <= 1'b0;
        end
    end

    // base high byte and mask share address B
    always @(posedge i_clock) begin
        if (i_rst) begin
            base <= 16'h0000;
            mask <= `VPI_MASK_RESET;
        end else if (wr_b) begin
            if (ini_pend)
                base <= {i_wdata, 8'h00};
            else
                mask <= i_wdata;
        end
    end

    // staging word for the source routing table
    always @(posedge i_clock) begin
        if (i_rst) begin
            map_level <= 3'h0;
            map_en    <= 1'b0;
        end else if (i_wr && i_addr == `VPI_ADDR_SRC) begin
            map_level <= i_wdata[2:0];
            map_en    <= i_wdata[3];
        end
    end

    // read mux; unmapped addresses and idle cycles read zero
    always @* begin
        next_rdata = 8'h00;
        if (i_rd) begin
            case (i_addr)
                `VPI_ADDR_A:
                    if (mode == `VPI_MODE_POLLED)
                        next_rdata = {has_win, 4'h0, win_lvl};
                    else if (rd_isr)
                        next_rdata = isr;
                    else
                        next_rdata = irr;
                `VPI_ADDR_B:
                    if (ini_pend)
                        next_rdata = base[15:8];
                    else
                        next_rdata = mask;
                `VPI_ADDR_SRC:
                    next_rdata = {4'h0, map_en, map_level};
                default:
                    next_rdata = 8'h00;
            endcase
        end
    end

    // read data stand only in the cycle after the strobe
    always @(posedge i_clock) begin
        if (i_rst)
            o_rdata <= 8'h00;
        else
            o_rdata <= next_rdata;
    end
endmodule
`default_nettype wire

// ### bench/vpi_unit_checker.sv
`timescale 1ns/1ps
`default_nettype none
module vpi_unit_checker (
    input wire logic        i_clock,
    input wire logic        i_rst,
    input wire logic        i_rd,
    input wire logic [7:0]  o_rdata,
    input wire logic        o_int,
    input wire logic        i_inta,
    input wire logic [15:0] o_vector,
    input wire logic        o_vector_valid
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);
    sequence s_ack;
        i_inta && o_int;
    endsequence
    sequence s_noack;
        i_inta && !o_int;
    endsequence
    a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data outside its slot");
    a_ack_vector: assert property (s_ack |=> o_vector_valid)
        else $error("accepted ack gave no vector");
    a_ack_refused: assert property (s_noack |=> !o_vector_valid)
        else $error("vector without pending interrupt");
    a_valid_cause: assert property (o_vector_valid |-> $past(i_inta))
        else $error("vector valid without ack");
    a_vector_hold: assert property (!o_vector_valid |-> $stable(o_vector))
        else $error("vector moved between acks");
    a_vector_align: assert property (o_vector_valid |-> o_vector[1:0] == 2'h0)
        else $error("vector not on entry spacing");
    a_table_size: assert property (o_vector_valid |-> o_vector[7:6] == 2'h0)
        else $error("vector outside its table");
    a_reset_quiet: assert property ($past(i_rst) |-> !o_int)
        else $error("interrupt with all levels masked");
endmodule
`default_nettype wire

// ### bench/vpi_peer.sv
`timescale 1ns/1ps
`default_nettype none
module vpi_peer (
    input  wire logic [25:0] i_raise,
    output wire logic [3:0]  o_in_full,
    output wire logic [3:0]  o_out_empty,
    output wire logic        o_rx_ready,
    output wire logic        o_tx_empty,
    output wire logic [1:0]  o_timer,
    output wire logic [8:0]  o_bus,
    output wire logic [7:0]  o_ext,
    output wire logic        o_mains_low
);
    // requests are held levels; a source drops only once it was serviced
    assign o_in_full   = i_raise[3:0];
    assign o_out_empty = i_raise[3:0];
    assign o_rx_ready  = i_raise[4];
    assign o_tx_empty  = i_raise[5];
    assign o_timer     = i_raise[7:6];
    assign o_bus       = i_raise[16:8];
    assign o_ext       = i_raise[24:17];
    assign o_mains_low = i_raise[25];
endmodule
`default_nettype wire

// ### bench/vpi_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
module vpi_unit_test;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        inta = 1'b0;
    logic [25:0] raise = 26'h0;
    logic [15:0] base = 16'h0000;
    int          sp = 4;
    int          n_fail = 0;
    int          total_checks = 0;
    wire  [7:0]  rdata;
    wire  [15:0] vec;
    wire  [3:0]  pfull, pempty;
    wire  [1:0]  tmr;
    wire  [8:0]  bus;
    wire  [7:0]  ext;
    wire         irq, vval, rx, tx, mlow;
    vpi_peer i_peer (.i_raise(raise), .o_in_full(pfull), .o_out_empty(pempty),
        .o_rx_ready(rx), .o_tx_empty(tx), .o_timer(tmr), .o_bus(bus),
        .o_ext(ext), .o_mains_low(mlow));
    vpi_unit i_dut (.i_clock(clock), .i_rst(rst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_ppi_in_full(pfull), .i_ppi_out_empty(pempty), .i_ser_rx_ready(rx),
        .i_ser_tx_empty(tx), .i_timer_out(tmr), .i_bus_int(bus),
        .i_ext_int(ext), .i_mains_low_warning(mlow), .o_int(irq),
        .i_inta(inta), .o_vector(vec), .o_vector_valid(vval));
    initial begin
        forever #2 clock = ~clock;
    end
    task automatic results;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 chk({8'h00, rdata}, {8'h00, exp});
        @(posedge clock);
    endtask
    // a mode word turns the next DB write into the base byte, so pair them
    task automatic mode(input logic [7:0] m);
        wr_reg(8'hDA, m);
        wr_reg(8'hDB, base[15:8]);
    endtask
    task automatic svc(input int lvl, input bit drop);
        int k;
        k = 0;
        while (k < 40) begin
            #1;
            if (irq === 1'b1) break;
            @(posedge clock);
            k++;
        end
        chk({15'h0, irq}, 16'h0001);
        if (k == 40) results();
        @(posedge clock);
        inta <= 1'b1;
        @(posedge clock);
        inta <= 1'b0;
        #1 chk(vec, base | 16'(lvl * sp));
        chk({15'h0, vval}, 16'h0001);
        @(posedge clock);
        if (drop) raise <= raise & ~(26'h100 << lvl) & ~26'h2000000;
        // pins pass a synchroniser before the request drops
        repeat (8) @(posedge clock);
        wr_reg(8'hDA, 8'h20);
    endtask
    task automatic t_reset;
        rd_chk(8'hDB, 8'hFF);
        rd_chk(8'h40, 8'h00);
        for (int l = 0; l < 8; l++) begin
            wr_reg(8'hD0, {5'h01, l[2:0]});
            wr_reg(8'hD1, 8'(8 + l));
        end
        wr_reg(8'hD0, 8'h0C);
        wr_reg(8'hD1, 8'd25);
    endtask
    task automatic t_nested;
        wr_reg(8'hDB, 8'h04);
        raise <= 26'h2000000 | 26'h400 | 26'h2000;
        svc(4, 1);
        svc(5, 1);
        wr_reg(8'hDB, 8'h00);
        svc(2, 1);
    endtask
    task automatic t_vector;
        base = 16'h1200;
        sp = 8;
        mode(8'h84);
        raise <= 26'h8000;
        svc(7, 1);
    endtask
    task automatic t_specific;
        mode(8'h86);
        wr_reg(8'hDA, 8'h43);
        raise <= 26'h400 | 26'h2000;
        svc(5, 1);
        svc(2, 1);
    endtask
    task automatic t_rotate;
        mode(8'h85);
        wr_reg(8'hDA, 8'h47);
        raise <= 26'h200 | 26'h4000;
        repeat (8) @(posedge clock);
        rd_chk(8'hDA, 8'h42);
        svc(1, 0);
        svc(6, 1);
        svc(1, 1);
    endtask
    task automatic t_polled;
        mode(8'h87);
        raise <= 26'h800;
        repeat (10) @(posedge clock);
        chk({15'h0, irq}, 16'h0000);
        rd_chk(8'hDA, 8'h83);
        raise <= 26'h0;
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_reset();
        t_nested();
        t_vector();
        t_specific();
        t_rotate();
        t_polled();
        results();
    end
endmodule
bind vpi_unit vpi_unit_checker i_chk (.i_clock(i_clock), .i_rst(i_rst),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_int(o_int), .i_inta(i_inta),
    .o_vector(o_vector), .o_vector_valid(o_vector_valid));
`default_nettype wire
